/* File: rtl/actr_pkg.sv */
// shared constants and types of the adc core trim register bank
package actr_pkg;
  localparam int ACTR_ADDR_W = 12;
  localparam int ACTR_DATA_W = 32;
  localparam int ACTR_STRB_W = 4;
  localparam int ACTR_IDX_W = 10;
  localparam int ACTR_OFS_W = 12;
  localparam int ACTR_OFS_REG_W = 16;
  localparam int ACTR_GAIN_W = 5;
  localparam int ACTR_GAIN_REG_W = 8;
  localparam int ACTR_NUM_OFS = 2;
  localparam int ACTR_NUM_GAIN = 6;
  localparam int ACTR_NUM_TRIM = 8;
  localparam int ACTR_SLOT_W = 3;
  localparam int ACTR_FUSE_W = 16;
  // register indices; the byte address is four times the index
  localparam logic [9:0] ACTR_IDX_CORE4_OFFSET_TRIM = 10'h33C;
  localparam logic [9:0] ACTR_IDX_CORE5_OFFSET_TRIM = 10'h33E;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_ZERO = 10'h360;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_ONE = 10'h361;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_TWO_A = 10'h362;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_TWO_B = 10'h363;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_THREE_C = 10'h364;
  localparam logic [9:0] ACTR_IDX_FINE_GAIN_CORE_THREE_D = 10'h365;
  localparam logic [9:0] ACTR_IDX_TRIM_STATUS = 10'h370;
  // storage slots; also the order of words in the fuse rom
  localparam logic [2:0] ACTR_SLOT_CORE4_OFS = 3'h0;
  localparam logic [2:0] ACTR_SLOT_CORE5_OFS = 3'h1;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_ZERO = 3'h2;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_ONE = 3'h3;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_TWO_INPUT_A = 3'h4;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_TWO_INPUT_B = 3'h5;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_THREE_INPUT_C = 3'h6;
  localparam logic [2:0] ACTR_SLOT_FINE_GAIN_CORE_THREE_INPUT_D = 3'h7;
  localparam logic [15:0] ACTR_OFS_RST = 16'h0000;
  localparam logic [7:0] ACTR_GAIN_RST = 8'h00;
  localparam logic [31:0] ACTR_RDATA_RST = 32'h0000_0000;
  // status register bit positions
  localparam int ACTR_STAT_LOADED = 0;
  localparam int ACTR_STAT_CAL_BUSY = 1;
  localparam int ACTR_STAT_SEL2 = 2;
  localparam int ACTR_STAT_SEL3 = 3;
  typedef enum logic [0:0] {ACTR_LD_FETCH, ACTR_LD_IDLE} actr_load_state_type;
endpackage

/* File: rtl/actr_fuse_loader.sv */
// fuse rom sequencer that streams factory trims into the bank
`timescale 1ns/1ps
module actr_fuse_loader
  import actr_pkg::*;
#(
  parameter int NUM_WORDS = ACTR_NUM_TRIM
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  output logic o_fuse_req,
  output logic [ACTR_SLOT_W-1:0] o_fuse_addr,
  input wire logic i_fuse_ack,
  input wire logic [ACTR_FUSE_W-1:0] i_fuse_data,
  output logic o_load_we,
  output logic [ACTR_SLOT_W-1:0] o_load_slot,
  output logic [ACTR_FUSE_W-1:0] o_load_data,
  output logic o_done
);
  if (NUM_WORDS < 1 || NUM_WORDS > (1 << ACTR_SLOT_W)) begin : g_chk
    $error("fuse word count out of range");
  end
  localparam logic [ACTR_SLOT_W-1:0] LAST = ACTR_SLOT_W'(NUM_WORDS - 1);
  actr_load_state_type state_ff;
  logic [ACTR_SLOT_W-1:0] addr_ff;
  logic we_ff;
  logic [ACTR_SLOT_W-1:0] slot_ff;
  logic [ACTR_FUSE_W-1:0] data_ff;
  logic done_ff;
  logic take;

  assign o_fuse_req = (state_ff == ACTR_LD_FETCH);
  assign take = o_fuse_req & i_fuse_ack;
  assign o_fuse_addr = addr_ff;

  // fetch starts at reset release; one word per acknowledge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ACTR_LD_FETCH;
      addr_ff <= '0;
    end else if (take) begin
      unique case (state_ff)
        ACTR_LD_FETCH: begin
          if (addr_ff == LAST) begin
            state_ff <= ACTR_LD_IDLE;
          end else begin
            addr_ff <= addr_ff + 1'b1;
          end
        end
        ACTR_LD_IDLE: state_ff <= ACTR_LD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      we_ff <= 1'b0;
      slot_ff <= '0;
      data_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      we_ff <= take;
      done_ff <= (state_ff == ACTR_LD_IDLE);
      if (take) begin
        slot_ff <= addr_ff;
        data_ff <= i_fuse_data;
      end
    end
  end

  assign o_load_we = we_ff;
  assign o_load_slot = slot_ff;
  assign o_load_data = data_ff;
  assign o_done = done_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  a_fuse_word_taken: assert property (
    take |=> o_load_we && o_load_slot == $past(addr_ff)
      && o_load_data == $past(i_fuse_data))
    else $error("fuse word not forwarded");
  a_fuse_addr_hold: assert property (
    o_fuse_req && !i_fuse_ack |=> $stable(o_fuse_addr))
    else $error("fuse address moved while waiting");
  a_done_sticky: assert property (
    o_done |=> o_done && !o_fuse_req)
    else $error("loader restarted after done");
endmodule // actr_fuse_loader

/* File: rtl/actr_gain_select.sv */
// picks the fine gain matching the analog input a core samples
`timescale 1ns/1ps
module actr_gain_select
  import actr_pkg::*;
#(
  parameter int WIDTH = ACTR_GAIN_W
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_sel_alt,
  input wire logic [WIDTH-1:0] i_gain_main,
  input wire logic [WIDTH-1:0] i_gain_alt,
  output logic [WIDTH-1:0] o_gain
);
  if (WIDTH < 1) begin : g_chk
    $error("gain width must be positive");
  end
  logic [WIDTH-1:0] gain_ff;

  // registered so the core sees no glitch when the input switches
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gain_ff <= '0;
    end else begin
      gain_ff <= i_sel_alt ? i_gain_alt : i_gain_main;
    end
  end
  assign o_gain = gain_ff;

  a_gain_follows: assert property (
    @(posedge i_clk) disable iff (!i_arst_n)
    1'b1 |=> o_gain == ($past(i_sel_alt) ? $past(i_gain_alt)
      : $past(i_gain_main)))
    else $error("gain does not follow input select");
endmodule // actr_gain_select

/* File: rtl/actr_top.sv */
// apb register bank holding per-core offset and fine-gain trims
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - core 4 offset trim at index 33C
// - core 5 offset trim at index 33E
// - core 0 fine gain at index 360
// - core 1 fine gain at index 361
// - core 2 gain follows its selected input
// - core 3 gain follows its selected input
// - fine gains default from fuse rom
// - core 4, 5 offsets default from fuse
// - offset trims applied as unsigned
module actr_top
  import actr_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_ARST_N,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ACTR_ADDR_W-1:0] I_PADDR,
  input wire logic [ACTR_DATA_W-1:0] I_PWDATA,
  input wire logic [ACTR_STRB_W-1:0] I_PSTRB,
  output logic [ACTR_DATA_W-1:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  output logic O_FUSE_REQ,
  output logic [ACTR_SLOT_W-1:0] O_FUSE_ADDR,
  input wire logic I_FUSE_ACK,
  input wire logic [ACTR_FUSE_W-1:0] I_FUSE_DATA,
  input wire logic I_OFS_CAL_BUSY,
  input wire logic I_CORE2_SEL_SECOND,
  input wire logic I_CORE3_SEL_FOURTH,
  output logic [ACTR_OFS_W-1:0] O_CORE4_OFFSET,
  output logic [ACTR_OFS_W-1:0] O_CORE5_OFFSET,
  output logic [ACTR_GAIN_W-1:0] O_CORE0_GAIN,
  output logic [ACTR_GAIN_W-1:0] O_CORE1_GAIN,
  output logic [ACTR_GAIN_W-1:0] O_CORE2_GAIN,
  output logic [ACTR_GAIN_W-1:0] O_CORE3_GAIN,
  output logic O_TRIM_LOADED
);

  // decoded access: {status, hit, slot}
  function automatic logic [4:0] actr_decode(
    input logic [ACTR_ADDR_W-1:0] addr
  );
    logic [ACTR_IDX_W-1:0] idx;
    idx = addr[ACTR_ADDR_W-1:2];
    actr_decode = 5'h00;
    if (addr[1:0] == 2'h0) begin
      case (idx)
        ACTR_IDX_CORE4_OFFSET_TRIM:
          actr_decode = {2'b01, ACTR_SLOT_CORE4_OFS};
        ACTR_IDX_CORE5_OFFSET_TRIM:
          actr_decode = {2'b01, ACTR_SLOT_CORE5_OFS};
        ACTR_IDX_FINE_GAIN_CORE_ZERO:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_ZERO};
        ACTR_IDX_FINE_GAIN_CORE_ONE:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_ONE};
        ACTR_IDX_FINE_GAIN_CORE_TWO_A:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_TWO_INPUT_A};
        ACTR_IDX_FINE_GAIN_CORE_TWO_B:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_TWO_INPUT_B};
        ACTR_IDX_FINE_GAIN_CORE_THREE_C:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_THREE_INPUT_C};
        ACTR_IDX_FINE_GAIN_CORE_THREE_D:
          actr_decode = {2'b01, ACTR_SLOT_FINE_GAIN_CORE_THREE_INPUT_D};
        ACTR_IDX_TRIM_STATUS:
          actr_decode = 5'h10;
        default:
          actr_decode = 5'h00;
      endcase
    end
  endfunction

  function automatic logic slot_is_ofs(
    input logic [ACTR_SLOT_W-1:0] slot
  );
    slot_is_ofs = (slot < ACTR_SLOT_FINE_GAIN_CORE_ZERO);
  endfunction

  function automatic logic [ACTR_SLOT_W-1:0] gain_index(
    input logic [ACTR_SLOT_W-1:0] slot
  );
    gain_index = slot - ACTR_SLOT_FINE_GAIN_CORE_ZERO;
  endfunction

  logic [ACTR_OFS_REG_W-1:0] ofs_ff [ACTR_NUM_OFS];
  logic [ACTR_GAIN_REG_W-1:0] gain_ff [ACTR_NUM_GAIN];
  logic [ACTR_DATA_W-1:0] prdata_ff;
  logic [ACTR_DATA_W-1:0] nxt_prdata;
  logic ready_ff;
  logic load_we;
  logic [ACTR_SLOT_W-1:0] load_slot;
  logic [ACTR_FUSE_W-1:0] load_data;
  logic load_done;
  logic [4:0] dec;
  logic dec_stat;
  logic dec_hit;
  logic [ACTR_SLOT_W-1:0] dec_slot;
  logic dec_ofs;
  logic access;
  logic done_xfer;
  logic ofs_blocked;
  logic acc_err;
  logic wr_ok;

  actr_fuse_loader #(
    .NUM_WORDS(ACTR_NUM_TRIM)
  ) u_loader (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .o_fuse_req(O_FUSE_REQ),
    .o_fuse_addr(O_FUSE_ADDR),
    .i_fuse_ack(I_FUSE_ACK),
    .i_fuse_data(I_FUSE_DATA),
    .o_load_we(load_we),
    .o_load_slot(load_slot),
    .o_load_data(load_data),
    .o_done(load_done)
  );

  assign dec = actr_decode(I_PADDR);
  assign dec_stat = dec[4];
  assign dec_hit = dec[3];
  assign dec_slot = dec[ACTR_SLOT_W-1:0];
  assign dec_ofs = dec_hit & slot_is_ofs(dec_slot);

  assign access = I_PSEL & I_PENABLE;
  assign done_xfer = access & ready_ff;
  assign ofs_blocked = dec_ofs & I_OFS_CAL_BUSY;
  // status is read-only; writing it is reported as an error
  assign acc_err = ~(dec_hit | dec_stat) | ofs_blocked
    | (dec_stat & I_PWRITE);
  assign wr_ok = done_xfer & I_PWRITE & ~acc_err;

  // bus stays stalled until fuse defaults are in place; the extra
  // stage lets the last fuse write land before read data is sampled
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= load_done;
    end
  end

  assign O_PREADY = ready_ff;
  assign O_PSLVERR = done_xfer & acc_err;
  assign O_TRIM_LOADED = ready_ff;

  // offset trims: fuse load has priority, bus is stalled meanwhile
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < ACTR_NUM_OFS; i++) begin
        ofs_ff[i] <= ACTR_OFS_RST;
      end
    end else if (load_we) begin
      if (slot_is_ofs(load_slot)) begin
        ofs_ff[load_slot[0]] <= load_data;
      end
    end else if (wr_ok && dec_ofs) begin
      // reserved upper bits are stored as written
      if (I_PSTRB[0]) begin
        ofs_ff[dec_slot[0]][7:0] <= I_PWDATA[7:0];
      end
      if (I_PSTRB[1]) begin
        ofs_ff[dec_slot[0]][15:8] <= I_PWDATA[15:8];
      end
    end
  end

  // fine gain trims
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < ACTR_NUM_GAIN; i++) begin
        gain_ff[i] <= ACTR_GAIN_RST;
      end
    end else if (load_we) begin
      if (!slot_is_ofs(load_slot)) begin
        gain_ff[gain_index(load_slot)] <= load_data[7:0];
      end
    end else if (wr_ok && dec_hit && !dec_ofs && I_PSTRB[0]) begin
      gain_ff[gain_index(dec_slot)] <= I_PWDATA[7:0];
    end
  end

  always_comb begin
    nxt_prdata = ACTR_RDATA_RST;
    if (dec_stat) begin
      nxt_prdata[ACTR_STAT_LOADED] = ready_ff;
      nxt_prdata[ACTR_STAT_CAL_BUSY] = I_OFS_CAL_BUSY;
      nxt_prdata[ACTR_STAT_SEL2] = I_CORE2_SEL_SECOND;
      nxt_prdata[ACTR_STAT_SEL3] = I_CORE3_SEL_FOURTH;
    end else if (dec_ofs) begin
      nxt_prdata[ACTR_OFS_REG_W-1:0] = ofs_ff[dec_slot[0]];
    end else if (dec_hit) begin
      nxt_prdata[ACTR_GAIN_REG_W-1:0] = gain_ff[gain_index(dec_slot)];
    end
  end

  // sampled through setup and wait cycles, held after completion
  always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      prdata_ff <= ACTR_RDATA_RST;
    end else if (I_PSEL && !done_xfer) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign O_PRDATA = prdata_ff;

  // plain binary code to the core, no sign extension
  assign O_CORE4_OFFSET = ofs_ff[0][ACTR_OFS_W-1:0];
  assign O_CORE5_OFFSET = ofs_ff[1][ACTR_OFS_W-1:0];
  assign O_CORE0_GAIN = gain_ff[0][ACTR_GAIN_W-1:0];
  assign O_CORE1_GAIN = gain_ff[1][ACTR_GAIN_W-1:0];

  actr_gain_select #(
    .WIDTH(ACTR_GAIN_W)
  ) u_core2_gain (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .i_sel_alt(I_CORE2_SEL_SECOND),
    .i_gain_main(gain_ff[2][ACTR_GAIN_W-1:0]),
    .i_gain_alt(gain_ff[3][ACTR_GAIN_W-1:0]),
    .o_gain(O_CORE2_GAIN)
  );

  actr_gain_select #(
    .WIDTH(ACTR_GAIN_W)
  ) u_core3_gain (
    .i_clk(I_CORE_CLK),
    .i_arst_n(I_ARST_N),
    .i_sel_alt(I_CORE3_SEL_FOURTH),
    .i_gain_main(gain_ff[4][ACTR_GAIN_W-1:0]),
    .i_gain_alt(gain_ff[5][ACTR_GAIN_W-1:0]),
    .o_gain(O_CORE3_GAIN)
  );

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_stall_until_loaded: assert property (
    !load_done |-> !O_PREADY ##1 !O_PREADY)
    else $error("bus answered before fuse load finished");

  a_fuse_gain_zero: assert property (
    load_we && load_slot == ACTR_SLOT_FINE_GAIN_CORE_ZERO
      |=> O_CORE0_GAIN == $past(load_data[ACTR_GAIN_W-1:0]))
    else $error("fuse gain for core 0 not applied");

  a_fuse_ofs_four: assert property (
    load_we && load_slot == ACTR_SLOT_CORE4_OFS
      |=> O_CORE4_OFFSET == $past(load_data[ACTR_OFS_W-1:0]))
    else $error("fuse offset for core 4 not applied");

  a_core4_offset_trim_bus_write: assert property (
    wr_ok && dec_hit && dec_slot == ACTR_SLOT_CORE4_OFS
      && I_PSTRB[1:0] == 2'h3
      |=> O_CORE4_OFFSET == $past(I_PWDATA[ACTR_OFS_W-1:0]))
    else $error("core 4 offset write lost");

  a_core5_offset_trim_bus_write: assert property (
    wr_ok && dec_hit && dec_slot == ACTR_SLOT_CORE5_OFS
      && I_PSTRB[1:0] == 2'h3
      |=> O_CORE5_OFFSET == $past(I_PWDATA[ACTR_OFS_W-1:0]))
    else $error("core 5 offset write lost");

  a_fine_gain_core_zero_bus_write: assert property (
    wr_ok && dec_hit && dec_slot == ACTR_SLOT_FINE_GAIN_CORE_ZERO && I_PSTRB[0]
      |=> O_CORE0_GAIN == $past(I_PWDATA[ACTR_GAIN_W-1:0]))
    else $error("core 0 gain write lost");

  a_fine_gain_core_one_bus_write: assert property (
    wr_ok && dec_hit && dec_slot == ACTR_SLOT_FINE_GAIN_CORE_ONE && I_PSTRB[0]
      |=> O_CORE1_GAIN == $past(I_PWDATA[ACTR_GAIN_W-1:0]))
    else $error("core 1 gain write lost");

  a_core2_second_input: assert property (
    I_CORE2_SEL_SECOND && $stable(gain_ff[3]) ##1
      I_CORE2_SEL_SECOND && $stable(gain_ff[3])
      |-> O_CORE2_GAIN == gain_ff[3][ACTR_GAIN_W-1:0])
    else $error("core 2 ignores its second input gain");

  a_core3_fourth_input: assert property (
    I_CORE3_SEL_FOURTH && $stable(gain_ff[5]) ##1
      I_CORE3_SEL_FOURTH && $stable(gain_ff[5])
      |-> O_CORE3_GAIN == gain_ff[5][ACTR_GAIN_W-1:0])
    else $error("core 3 ignores its fourth input gain");

  a_cal_busy_guard: assert property (
    done_xfer && dec_ofs && I_OFS_CAL_BUSY
      |-> O_PSLVERR ##1 $stable(O_CORE4_OFFSET)
      && $stable(O_CORE5_OFFSET))
    else $error("offset access during calibration not refused");

  a_gain_read_upper: assert property (
    done_xfer && !I_PWRITE && dec_hit && !dec_ofs
      |-> O_PRDATA[ACTR_DATA_W-1:ACTR_GAIN_REG_W] == '0)
    else $error("gain read shows bits above the register");

  a_unmapped_error: assert property (
    done_xfer && !dec_hit && !dec_stat |-> O_PSLVERR
      && O_PRDATA == ACTR_RDATA_RST)
    else $error("unmapped access not answered with error");

  a_fuse_ofs_five: assert property (
    load_we && load_slot == ACTR_SLOT_CORE5_OFS
      |=> O_CORE5_OFFSET == $past(load_data[ACTR_OFS_W-1:0]))
    else $error("fuse offset for core 5 not applied");

  a_fuse_gain_one: assert property (
    load_we && load_slot == ACTR_SLOT_FINE_GAIN_CORE_ONE
      |=> O_CORE1_GAIN == $past(load_data[ACTR_GAIN_W-1:0]))
    else $error("fuse gain for core 1 not applied");

  a_ready_after_load: assert property (
    load_done |=> O_PREADY)
    else $error("bus still stalled after fuse load");

  a_core2_first_input: assert property (
    !I_CORE2_SEL_SECOND && $stable(gain_ff[2]) ##1
      !I_CORE2_SEL_SECOND && $stable(gain_ff[2])
      |-> O_CORE2_GAIN == gain_ff[2][ACTR_GAIN_W-1:0])
    else $error("core 2 ignores its first input gain");

  a_core3_third_input: assert property (
    !I_CORE3_SEL_FOURTH && $stable(gain_ff[4]) ##1
      !I_CORE3_SEL_FOURTH && $stable(gain_ff[4])
      |-> O_CORE3_GAIN == gain_ff[4][ACTR_GAIN_W-1:0])
    else $error("core 3 ignores its third input gain");

  a_ofs_read_upper: assert property (
    done_xfer && !I_PWRITE && dec_ofs
      |-> O_PRDATA[ACTR_DATA_W-1:ACTR_OFS_REG_W] == '0)
    else $error("offset read shows bits above the register");

  a_fine_gain_core_three_input_d_bus_write: assert property (
    wr_ok && dec_hit && dec_slot == ACTR_SLOT_FINE_GAIN_CORE_THREE_INPUT_D && I_PSTRB[0]
      |=> gain_ff[5][ACTR_GAIN_W-1:0] == $past(I_PWDATA[ACTR_GAIN_W-1:0]))
    else $error("core 3 fourth input gain write lost");
endmodule // actr_top

/* File: test/actr_top_tb_top.sv */
// apb register and fuse-load bench for the core trim register bank
`timescale 1ns/1ps
module actr_top_tb_top;
  import actr_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ACTR_ADDR_W-1:0] paddr = '0;
  logic [ACTR_DATA_W-1:0] pwdata = '0;
  logic [ACTR_STRB_W-1:0] pstrb = '0;
  logic fuse_ack = 1'b0;
  logic [ACTR_FUSE_W-1:0] fuse_data = '0;
  logic cal_busy = 1'b0;
  logic sel2 = 1'b0;
  logic sel3 = 1'b0;
  wire logic [ACTR_DATA_W-1:0] prdata;
  wire logic pready, pslverr, fuse_req, loaded;
  wire logic [ACTR_SLOT_W-1:0] fuse_addr;
  wire logic [ACTR_OFS_W-1:0] core4_offset_trim, core5_offset_trim;
  wire logic [ACTR_GAIN_W-1:0] g0, g1, g2, g3;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [9:0] idx [8] = '{ACTR_IDX_CORE4_OFFSET_TRIM,
    ACTR_IDX_CORE5_OFFSET_TRIM, ACTR_IDX_FINE_GAIN_CORE_ZERO,
    ACTR_IDX_FINE_GAIN_CORE_ONE, ACTR_IDX_FINE_GAIN_CORE_TWO_A,
    ACTR_IDX_FINE_GAIN_CORE_TWO_B, ACTR_IDX_FINE_GAIN_CORE_THREE_C,
    ACTR_IDX_FINE_GAIN_CORE_THREE_D};
  // factory words keep reserved bits zero, as software must
  logic [15:0] fuse_v [8] = '{16'h0123, 16'h0ABC, 16'h0011, 16'h0002,
    16'h000C, 16'h001B, 16'h0005, 16'h0013};
  logic [15:0] new_v [8] = '{16'h0800, 16'h0FFF, 16'h001F, 16'h0001,
    16'h0010, 16'h000A, 16'h0015, 16'h0007};
  logic [15:0] exp_v [8];
  logic [31:0] rd;
  logic er;

  actr_top dut (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_FUSE_REQ(fuse_req),
    .O_FUSE_ADDR(fuse_addr), .I_FUSE_ACK(fuse_ack),
    .I_FUSE_DATA(fuse_data), .I_OFS_CAL_BUSY(cal_busy),
    .I_CORE2_SEL_SECOND(sel2), .I_CORE3_SEL_FOURTH(sel3),
    .O_CORE4_OFFSET(core4_offset_trim), .O_CORE5_OFFSET(core5_offset_trim), .O_CORE0_GAIN(g0),
    .O_CORE1_GAIN(g1), .O_CORE2_GAIN(g2), .O_CORE3_GAIN(g3),
    .O_TRIM_LOADED(loaded));

  initial begin
    forever #4 clk = ~clk;
  end

  // slow fuse rom: acknowledges every other cycle to stretch the load
  always @(posedge clk) begin
    fuse_ack <= fuse_req && !fuse_ack;
    fuse_data <= fuse_v[fuse_addr];
  end

  task report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits on pready with a bound, no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the rising edge that completes the access
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({core4_offset_trim, core5_offset_trim}, 32'h0);
    chk({g0, g1}, 32'h0);
    chk({g2, g3, pready, loaded, fuse_req}, 32'h1);
    chk(fuse_addr, 32'h0);
    @(posedge clk);
    arst_n <= 1'b1;
  endtask

  // checks every trim output; core 2/3 swept through both inputs
  task chk_outs;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      sel2 <= s[0];
      sel3 <= s[0];
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(g2, exp_v[4+s][4:0]);
      chk(g3, exp_v[6+s][4:0]);
    end
    chk(core4_offset_trim, exp_v[0][11:0]);
    chk(core5_offset_trim, exp_v[1][11:0]);
    chk(g0, exp_v[2][4:0]);
    chk(g1, exp_v[3][4:0]);
    chk({loaded, fuse_req}, 32'h2);
  endtask

  task rd_all;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, {idx[i], 2'b00}, 32'h0, 4'h0);
      chk(rd, {16'h0, exp_v[i]});
      chk(er, 1'b0);
    end
  endtask

  initial begin
    exp_v = fuse_v;
    do_reset();
    // a read issued during the fuse load must wait for the defaults
    apb(1'b0, {idx[0], 2'b00}, 32'h0, 4'h0);
    chk(rd, {16'h0, fuse_v[0]});
    rd_all();
    chk_outs();
    for (int i = 0; i < 8; i++)
      apb(1'b1, {idx[i], 2'b00}, {16'h0, new_v[i]}, 4'hF);
    exp_v = new_v;
    rd_all();
    chk_outs();
    // upper lane only: low byte of the offset must survive
    apb(1'b1, {idx[0], 2'b00}, 32'h0000_0A55, 4'h2);
    exp_v[0] = {8'h0A, new_v[0][7:0]};
    apb(1'b0, {idx[0], 2'b00}, 32'h0, 4'h0);
    chk(rd, {16'h0, exp_v[0]});
    // offset access refused while offset calibration runs
    @(posedge clk);
    cal_busy <= 1'b1;
    apb(1'b1, {idx[1], 2'b00}, 32'h0000_0555, 4'hF);
    chk(er, 1'b1);
    apb(1'b0, {idx[1], 2'b00}, 32'h0, 4'h0);
    chk(er, 1'b1);
    apb(1'b1, {idx[2], 2'b00}, 32'h0000_0003, 4'hF);
    chk(er, 1'b0);
    exp_v[2] = 16'h0003;
    apb(1'b0, {ACTR_IDX_TRIM_STATUS, 2'b00}, 32'h0, 4'h0);
    chk(rd, 32'h0000_000F);
    @(posedge clk);
    cal_busy <= 1'b0;
    rd_all();
    // unmapped, misaligned and read-only places
    apb(1'b0, 12'hD98, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, {idx[0], 2'b00} + 12'h1, 32'h0000_0FFF, 4'hF);
    chk(er, 1'b1);
    apb(1'b1, {ACTR_IDX_TRIM_STATUS, 2'b00}, 32'h0, 4'hF);
    chk(er, 1'b1);
    apb(1'b0, {ACTR_IDX_TRIM_STATUS, 2'b00}, 32'h0, 4'h0);
    chk(rd, 32'h0000_000D);
    rd_all();
    // second reset in mid-run brings the factory trims back
    do_reset();
    exp_v = fuse_v;
    rd_all();
    chk_outs();
    report_and_stop();
  end
endmodule // actr_top_tb_top
